// >>> bsmr_pkg.sv
package bsmr_pkg;
   // protocol codes
   localparam logic [7:0] FC_READ_HOLDING = 8'h03;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
   localparam logic [15:0] MAX_READ_COUNT = 16'h007D;
   // register map: protocol address is register number minus one
   localparam logic [15:0] ADDR_QUALITY = 16'h7CFF;
   localparam logic [15:0] ADDR_STATUS = 16'h7D00;
   localparam logic [15:0] RANGE0_BASE = 16'h7CFF;
   localparam logic [15:0] RANGE0_LEN = 16'h007C;
   localparam logic [15:0] RANGE1_BASE = 16'h7D7B;
   localparam logic [15:0] RANGE1_LEN = 16'h0076;
   localparam logic [15:0] RANGE2_BASE = 16'h7E53;
   localparam logic [15:0] RANGE2_LEN = 16'h0060;
   // status word layout
   localparam int BIT_OPEN = 0;
   localparam int BIT_TRIP = 1;
   localparam int BIT_FAULT = 2;
   localparam int BIT_SPRING = 3;
   localparam int BIT_READY = 5;
   localparam int BIT_UNAVAIL = 15;
   localparam logic [15:0] QUALITY_DEFINED = 16'h802F;
   localparam logic [15:0] RESERVED_MASK = 16'h7FD0;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   // framing
   localparam logic [3:0] REQ_BYTES = 4'h8;
   localparam logic [7:0] HDR_BYTES = 8'h03;
   localparam logic [7:0] IDX_FUNC = 8'h01;
   localparam logic [7:0] IDX_COUNT = 8'h02;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;

   typedef enum logic [1:0] {ST_RX, ST_CHECK, ST_SEND} bsmr_state_e;
endpackage

// >>> bsmr_crc_if.sv
`timescale 1ns/1ps
interface bsmr_crc_if;
   logic clear;
   logic feed;
   logic [7:0] data;
   logic [15:0] crc;
   logic [15:0] crcNext;
   modport user (output clear, output feed, output data, input crc, input crcNext);
   modport unit (input clear, input feed, input data, output crc, output crcNext);
endinterface

// >>> bsmr_crc.sv
`timescale 1ns/1ps
module bsmr_crc
   import bsmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   bsmr_crc_if.unit port
);
   typedef struct packed {
      logic [15:0] crc;
   } bsmr_crc_s;

   bsmr_crc_s s;
   bsmr_crc_s next_s;

   // reflected crc over one byte, lsb first
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   assign port.crcNext = crcByte(s.crc, port.data);
   assign port.crc = s.crc;

   always_comb begin
      next_s = s;
      if (port.clear) begin
         next_s.crc = CRC_INIT;
      end else if (port.feed) begin
         next_s.crc = port.crcNext;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '{crc: CRC_INIT};
      end else begin
         s <= next_s;
      end
   end
endmodule // bsmr_crc

// >>> bsmr_regs.sv
// How it works
// - answer echoes slave, function, byte count, data
// - protocol address equals register number minus one
// - quality word sits at 0x7CFF
// - ranges at 0x7D7B and 0x7E53 served
// - quality bit marks status bit valid
// - bit 0 shows breaker closed
// - bit 1 shows breaker tripped
// - bit 2 shows electrical fault trip
// - bit 3 shows spring charged
// - bit 5 shows ready to close
// - motor mechanism forces bits 1,3,5 low
// - bit 15 flags data unavailable
`timescale 1ns/1ps
module bsmr_regs
   import bsmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] slaveAddr,
   input wire logic [7:0] rxByte,
   input wire logic rxValid,
   input wire logic frameGap,
   output logic [7:0] txByte,
   output logic txValid,
   input wire logic txReady,
   input wire logic openClosedContact,
   input wire logic tripContact,
   input wire logic faultTripContact,
   input wire logic springChargedContact,
   input wire logic readyToCloseContact,
   input wire logic motorMechanism,
   input wire logic dataUnavailable,
   input wire logic [15:0] contactValid,
   output logic [15:0] statusWord,
   output logic [15:0] qualityWord
);
   typedef struct packed {
      bsmr_state_e fsm;
      logic [3:0] rxIdx;
      logic [7:0] slave;
      logic [7:0] func;
      logic [15:0] start;
      logic [15:0] count;
      logic [7:0] excCode;
      logic [7:0] txIdx;
      logic [7:0] txByte;
      logic txValid;
      logic [15:0] status;
      logic [15:0] quality;
      logic [15:0] snapStatus;
      logic [15:0] snapQuality;
   } bsmr_regs_s;

   bsmr_regs_s s;
   bsmr_regs_s next_s;
   bsmr_crc_if ci();
   logic beat;
   logic [7:0] nBytes;

   bsmr_crc u_crc (
      .clk_sys(clk_sys),
      .rst(rst),
      .port(ci.unit)
   );

   function automatic logic inWindow(input logic [15:0] st, input logic [15:0] cnt,
                                     input logic [15:0] base, input logic [15:0] len);
      return (st >= base) && ({1'b0, st} + {1'b0, cnt} <= {1'b0, base} + {1'b0, len});
   endfunction

   // words outside this bank belong to other blocks and read zero here
   function automatic logic [15:0] regValue(input logic [15:0] a, input logic [15:0] q,
                                            input logic [15:0] w);
      if (a == ADDR_QUALITY) begin
         return q;
      end else if (a == ADDR_STATUS) begin
         return w;
      end
      return WORD_ZERO;
   endfunction

   function automatic logic [7:0] byteAt(input bsmr_regs_s r, input logic [7:0] idx);
      logic [7:0] j;
      logic [15:0] v;
      j = idx - HDR_BYTES;
      v = regValue(r.start + {9'h000, j[7:1]}, r.snapQuality, r.snapStatus);
      if (idx == 8'h00) begin
         return r.slave;
      end else if (idx == IDX_FUNC) begin
         return (r.excCode != EXC_NONE) ? (r.func | EXC_FLAG) : r.func;
      end else if (idx == IDX_COUNT) begin
         return (r.excCode != EXC_NONE) ? r.excCode : {r.count[6:0], 1'b0};
      end
      return j[0] ? v[7:0] : v[15:8];
   endfunction

   assign beat = s.txValid && txReady;
   assign nBytes = (s.excCode != EXC_NONE) ? HDR_BYTES : HDR_BYTES + {s.count[6:0], 1'b0};
   assign txByte = s.txByte;
   assign txValid = s.txValid;
   assign statusWord = s.status;
   assign qualityWord = s.quality;

   always_comb begin
      next_s = s;
      ci.clear = 1'b0;
      ci.feed = 1'b0;
      ci.data = (s.fsm == ST_SEND) ? s.txByte : rxByte;
      next_s.status = WORD_ZERO;
      next_s.status[BIT_OPEN] = openClosedContact;
      next_s.status[BIT_TRIP] = tripContact && !motorMechanism;
      next_s.status[BIT_FAULT] = faultTripContact;
      next_s.status[BIT_SPRING] = springChargedContact && !motorMechanism;
      // ready to close, motor forces low
      next_s.status[BIT_READY] = readyToCloseContact && !motorMechanism;
      next_s.status[BIT_UNAVAIL] = dataUnavailable;
      // validity per bit; reserved quality bits zero
      next_s.quality = contactValid & QUALITY_DEFINED;
      next_s.quality[BIT_UNAVAIL] = 1'b1;
      case (s.fsm)
         ST_RX: begin
            if (frameGap) begin
               next_s.rxIdx = '0;
               ci.clear = 1'b1;
            end else if (rxValid) begin
               ci.feed = 1'b1;
               next_s.rxIdx = s.rxIdx + 4'h1;
               case (s.rxIdx)
                  4'h0: next_s.slave = rxByte;
                  4'h1: next_s.func = rxByte;
                  4'h2: next_s.start[15:8] = rxByte;
                  4'h3: next_s.start[7:0] = rxByte;
                  4'h4: next_s.count[15:8] = rxByte;
                  4'h5: next_s.count[7:0] = rxByte;
                  default: ;
               endcase
               if (s.rxIdx == REQ_BYTES - 4'h1) begin
                  next_s.fsm = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            next_s.rxIdx = '0;
            ci.clear = 1'b1;
            // bad crc or another slave: stay silent
            if (ci.crc == CRC_RESIDUE && s.slave == slaveAddr) begin
               next_s.fsm = ST_SEND;
               next_s.snapStatus = s.status;
               next_s.snapQuality = s.quality;
               next_s.txIdx = '0;
               next_s.txByte = s.slave;
               next_s.txValid = 1'b1;
               if (s.func != FC_READ_HOLDING) begin
                  next_s.excCode = EXC_ILLEGAL_FUNCTION;
               end else if (s.count == WORD_ZERO || s.count > MAX_READ_COUNT) begin
                  next_s.excCode = EXC_ILLEGAL_VALUE;
               end else if (!(inWindow(s.start, s.count, RANGE0_BASE, RANGE0_LEN) ||
                              inWindow(s.start, s.count, RANGE1_BASE, RANGE1_LEN) ||
                              inWindow(s.start, s.count, RANGE2_BASE, RANGE2_LEN))) begin
                  next_s.excCode = EXC_ILLEGAL_ADDRESS;
               end else begin
                  next_s.excCode = EXC_NONE;
               end
            end else begin
               next_s.fsm = ST_RX;
            end
         end
         ST_SEND: begin
            if (beat) begin
               ci.feed = (s.txIdx < nBytes);
               // answer byte sequence, crc low byte first
               if (s.txIdx == nBytes + 8'h01) begin
                  next_s.fsm = ST_RX;
                  next_s.txValid = 1'b0;
                  next_s.txIdx = '0;
                  ci.clear = 1'b1;
               end else begin
                  next_s.txIdx = s.txIdx + 8'h01;
                  if (s.txIdx + 8'h01 < nBytes) begin
                     next_s.txByte = byteAt(s, s.txIdx + 8'h01);
                  end else if (s.txIdx + 8'h01 == nBytes) begin
                     next_s.txByte = ci.crcNext[7:0];
                  end else begin
                     next_s.txByte = ci.crc[15:8];
                  end
               end
            end
         end
         default: next_s.fsm = ST_RX;
      endcase
   end

   // nothing here writes the words; a write request is answered as exception
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '{fsm: ST_RX, default: '0};
      end else begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence checkPass;
      s.fsm == ST_CHECK && next_s.fsm == ST_SEND;
   endsequence
   sequence fullBankRead;
      s.func == FC_READ_HOLDING && s.start == ADDR_QUALITY && s.count == RANGE0_LEN;
   endsequence

   // the words show reset zeros one edge after release, so that edge is skipped
   open_bit_a: assert property (!$past(rst) |->
      statusWord[BIT_OPEN] == $past(openClosedContact))
      else $error("open bit does not follow contact");
   trip_bit_a: assert property (!$past(rst) && !$past(motorMechanism) |->
      statusWord[BIT_TRIP] == $past(tripContact))
      else $error("trip bit does not follow contact");
   fault_bit_a: assert property (!$past(rst) |->
      statusWord[BIT_FAULT] == $past(faultTripContact))
      else $error("fault bit does not follow contact");
   spring_bit_a: assert property (!$past(rst) && !$past(motorMechanism) |->
      statusWord[BIT_SPRING] == $past(springChargedContact))
      else $error("spring bit does not follow contact");
   ready_bit_a: assert property (!$past(rst) && !$past(motorMechanism) |->
      statusWord[BIT_READY] == $past(readyToCloseContact))
      else $error("ready bit does not follow contact");
   motor_zero_a: assert property (!$past(rst) && $past(motorMechanism) |->
      !statusWord[BIT_TRIP] && !statusWord[BIT_SPRING] && !statusWord[BIT_READY])
      else $error("motor variant shows a contact bit");
   unavail_bit_a: assert property (!$past(rst) |->
      statusWord[BIT_UNAVAIL] == $past(dataUnavailable))
      else $error("unavailable flag wrong");
   reserved_zero_a: assert property ((statusWord & RESERVED_MASK) == WORD_ZERO &&
      (qualityWord & ~QUALITY_DEFINED) == WORD_ZERO)
      else $error("reserved bit set");
   quality_bits_a: assert property (!$past(rst) |->
      qualityWord[BIT_OPEN] == $past(contactValid[BIT_OPEN]) && qualityWord[BIT_UNAVAIL])
      else $error("quality word wrong");
   resp_start_a: assert property (checkPass |=>
      txValid && txByte == s.slave && s.txIdx == 8'h00)
      else $error("answer does not open with slave address");
   byte_count_a: assert property (s.fsm == ST_SEND && s.txIdx == IDX_COUNT &&
      s.excCode == EXC_NONE |-> txByte == {s.count[6:0], 1'b0})
      else $error("byte count is not twice the register count");
   bank_map_a: assert property (checkPass ##0 fullBankRead |=> s.excCode == EXC_NONE)
      else $error("full first range refused");
   first_word_a: assert property (s.fsm == ST_SEND && s.txIdx == HDR_BYTES &&
      s.excCode == EXC_NONE && s.start == ADDR_STATUS |-> txByte == s.snapStatus[15:8])
      else $error("address 0x7D00 does not return the status word");
endmodule // bsmr_regs

// >>> bsmr_master_model.sv
`timescale 1ns/1ps
module bsmr_master_model
   import bsmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [7:0] txByte,
   input wire logic txValid,
   output logic txReady,
   output logic [7:0] rxByte,
   output logic rxValid,
   output logic frameGap
);
   logic [7:0] got[$];
   int seed = 32'h7258;
   initial begin
      txReady = 1'b0;
      rxByte = 8'hA5;
      rxValid = 1'b0;
      frameGap = 1'b0;
   end
   // random stalls: a slow master must not lose answer bytes
   always @(posedge clk_sys) begin
      if (txValid && txReady) got.push_back(txByte);
      txReady <= 1'($random(seed));
   end
   task automatic sendFrame(input logic [7:0] q[$]);
      @(posedge clk_sys);
      frameGap <= 1'b1;
      @(posedge clk_sys);
      frameGap <= 1'b0;
      foreach (q[i]) begin
         rxByte <= q[i];
         rxValid <= 1'b1;
         @(posedge clk_sys);
      end
      rxValid <= 1'b0;
      // released line shows the inverse, not a stale byte
      rxByte <= ~q[q.size()-1];
   endtask
endmodule // bsmr_master_model

// >>> testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin fails++; \
   $display("wrong value at %0t got %h expected %h", $time, g, e); end end
module testbench import bsmr_pkg::*;
   ;
   logic clk_sys, rst, rxValid, frameGap, txValid, txReady;
   logic openClosedContact, tripContact, faultTripContact, springChargedContact;
   logic readyToCloseContact, motorMechanism, dataUnavailable;
   logic [7:0] slaveAddr, rxByte, txByte;
   logic [15:0] contactValid, statusWord, qualityWord;
   int fails = 0;
   int checkCount = 0;
   int seed = 32'h7258;
   int k;
   bsmr_regs u_bsmr_regs (.clk_sys(clk_sys), .rst(rst), .slaveAddr(slaveAddr), .rxByte(rxByte),
      .rxValid(rxValid), .frameGap(frameGap), .txByte(txByte), .txValid(txValid),
      .txReady(txReady), .openClosedContact(openClosedContact), .tripContact(tripContact),
      .faultTripContact(faultTripContact), .springChargedContact(springChargedContact),
      .readyToCloseContact(readyToCloseContact), .motorMechanism(motorMechanism),
      .dataUnavailable(dataUnavailable), .contactValid(contactValid),
      .statusWord(statusWord), .qualityWord(qualityWord));
   bsmr_master_model u_bsmr_master_model (.clk_sys(clk_sys), .txByte(txByte),
      .txValid(txValid), .txReady(txReady), .rxByte(rxByte), .rxValid(rxValid),
      .frameGap(frameGap));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   function automatic logic [15:0] expStatus();
      return {dataUnavailable, 9'h000, readyToCloseContact & ~motorMechanism, 1'b0,
         springChargedContact & ~motorMechanism, faultTripContact,
         tripContact & ~motorMechanism, openClosedContact};
   endfunction
   function automatic logic [15:0] expQuality();
      return (contactValid & 16'h002F) | 16'h8000;
   endfunction
   function automatic logic [15:0] wordAt(input logic [15:0] a);
      return (a == 16'h7CFF) ? expQuality() : (a == 16'h7D00) ? expStatus() : 16'h0000;
   endfunction
   function automatic bit inRange(input int a, input int n);
      return (a >= 16'h7CFF && a + n <= 16'h7CFF + 124)
         || (a >= 16'h7D7B && a + n <= 16'h7D7B + 118)
         || (a >= 16'h7E53 && a + n <= 16'h7E53 + 96);
   endfunction
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   task automatic transact(input logic [7:0] sa, fc, input logic [15:0] ad, cn, input bit bad);
      logic [7:0] rq[$];
      logic [7:0] ex[$];
      logic [15:0] c;
      logic [15:0] w;
      logic [7:0] bc;
      int i;
      rq = {sa, fc, ad[15:8], ad[7:0], cn[15:8], cn[7:0]};
      c = crc16(rq) ^ {15'h0000, bad};
      rq.push_back(c[7:0]);
      rq.push_back(c[15:8]);
      if (sa == 8'hFF && !bad) begin
         bc = 8'(int'(cn) * 2);
         if (fc != 8'h03) ex = {sa, fc | 8'h80, 8'h01};
         else if (cn == 16'h0000 || cn > 16'h007D) ex = {sa, fc | 8'h80, 8'h03};
         else if (!inRange(int'(ad), int'(cn))) ex = {sa, fc | 8'h80, 8'h02};
         else begin
            ex = {sa, fc, bc};
            for (i = 0; i < int'(cn); i++) begin
               w = wordAt(ad + i[15:0]);
               ex.push_back(w[15:8]);
               ex.push_back(w[7:0]);
            end
         end
         c = crc16(ex);
         ex.push_back(c[7:0]);
         ex.push_back(c[15:8]);
      end
      u_bsmr_master_model.got.delete();
      u_bsmr_master_model.sendFrame(rq);
      for (i = 0; i < 5000 && u_bsmr_master_model.got.size() < ex.size(); i++) @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      `CHK(u_bsmr_master_model.got.size(), ex.size())
      foreach (ex[j]) `CHK(u_bsmr_master_model.got[j], ex[j])
   endtask
   task automatic finalReport();
      $display("comparisons %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys);
      fails++;
      finalReport();
   end
   initial begin
      rst = 1'b1;
      slaveAddr = 8'hFF;
      {openClosedContact, tripContact, faultTripContact, springChargedContact} = 4'h0;
      {readyToCloseContact, motorMechanism, dataUnavailable} = 3'h0;
      contactValid = 16'h0000;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK(txValid, 1'b0)
      @(posedge clk_sys);
      rst <= 1'b0;
      for (k = 0; k < 48; k++) begin
         @(posedge clk_sys);
         {openClosedContact, tripContact, faultTripContact, springChargedContact,
            readyToCloseContact, motorMechanism, dataUnavailable} <= 7'($random(seed));
         contactValid <= 16'($random(seed));
         repeat (2) @(posedge clk_sys);
         #1;
         `CHK(statusWord, expStatus())
         `CHK(qualityWord, expQuality())
         if (k % 8 == 0) transact(8'hFF, 8'h03, 16'h7CFF, 16'h0002, 1'b0);
      end
      transact(8'hFF, 8'h03, 16'h7CFF, 16'h007C, 1'b0);
      transact(8'hFF, 8'h03, 16'h7D7B, 16'h0076, 1'b0);
      transact(8'hFF, 8'h03, 16'h7E53, 16'h0060, 1'b0);
      transact(8'hFF, 8'h03, 16'h7CFF, 16'h007E, 1'b0);
      transact(8'hFF, 8'h03, 16'h7CFF, 16'h007D, 1'b0);
      transact(8'hFF, 8'h03, 16'h7D00, 16'h0000, 1'b0);
      transact(8'hFF, 8'h06, 16'h7D00, 16'h0001, 1'b0);
      transact(8'hFF, 8'h03, 16'h7D7A, 16'h0001, 1'b0);
      transact(8'h11, 8'h03, 16'h7D00, 16'h0001, 1'b0);
      transact(8'hFF, 8'h03, 16'h7D00, 16'h0001, 1'b1);
      transact(8'hFF, 8'h03, 16'h7D00, 16'h0001, 1'b0);
      finalReport();
   end
endmodule // testbench
